/* File: bss_pkg.sv */
// shared constants and types for the buck setpoint select block
package bss_pkg;

  // ---------------------------------------------------------------
  // power states from the sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BSS_OFF   = 2'b00,
    BSS_RUN   = 2'b01,
    BSS_STBY  = 2'b10,
    BSS_SLEEP = 2'b11
  } bss_pwr_state_t;

  // ---------------------------------------------------------------
  // setpoint carrier
  // ---------------------------------------------------------------
  localparam int unsigned CODE_W = 6;
  typedef struct packed {
    logic [CODE_W-1:0] run;
    logic [CODE_W-1:0] stby;
    logic [CODE_W-1:0] sleep;
  } bss_setpoints_t;
  localparam logic [CODE_W-1:0] CODE_RST = 6'h00;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] RUN_OFS = 8'h00;
  localparam logic [7:0] STBY_OFS = 8'h04;
  localparam logic [7:0] SLEEP_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_FUSE_BIT = 2;
  localparam int unsigned ST_WREN_BIT = 3;
  localparam int unsigned ST_CODE_LSB = 8;
  localparam int unsigned ST_TGT_LSB = 16;

  // ---------------------------------------------------------------
  // voltage tables, units of 100 uV
  // ---------------------------------------------------------------
  localparam int unsigned TGT_W = 16;
  localparam logic [TGT_W-1:0] DVS_BASE = 16'h1770;
  localparam logic [TGT_W-1:0] DVS_STEP = 16'h007d;
  localparam logic [CODE_W-1:0] FIX_LAST = 6'h07;
  localparam logic [TGT_W-1:0] FIX_TABLE [8] = '{
    16'h2af8, 16'h2ee0, 16'h34bc, 16'h3a98,
    16'h4650, 16'h61a8, 16'h7530, 16'h80e8
  };
  localparam logic [TGT_W-1:0] FIX_MAX = 16'h80e8;

  // ---------------------------------------------------------------
  // ahb-lite encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;

endpackage

/* File: bss_seq_model.sv */
// power sequencer and processor reset model facing the setpoint block
`timescale 1ns/1ps
module bss_seq_model
  import bss_pkg::*;
#(parameter int unsigned RELEASE_DLY = 8)
(
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire bss_pkg::bss_pwr_state_t req, // state asked by the bench
  output bss_pkg::bss_pwr_state_t state, // state shown to the block
  output logic proc_rst_out_n // high once processor reset is released
);
  import bss_pkg::*;
  logic [7:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= BSS_OFF;
      cnt_r <= 8'h00;
    end
    else
    begin
      state <= req;
      // late release leaves a gap where early writes can be tried
      if (state == BSS_OFF)
        cnt_r <= 8'h00;
      else if (cnt_r != 8'hff)
        cnt_r <= cnt_r + 8'h01;
    end
  end
  assign proc_rst_out_n = (32'(cnt_r) >= RELEASE_DLY);
endmodule

/* File: bss_top.sv */
// setpoint store, start-up load and target decode for one step-down converter
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module bss_top
  import bss_pkg::*;
(
  input wire logic CORE_CLK, // 100 MHz core clock
  input wire logic RESETN, // async reset, active low
  input wire bss_pkg::bss_pwr_state_t PWR_STATE, // state from sequencer
  input wire logic PROC_RESET_OUT_N, // processor reset out, high once released
  input wire logic [5:0] FUSED_SETPOINT_CODE, // fused default code
  input wire logic SCALING_SELECT_FUSE, // 0 scaling enabled, 1 fixed table
  input wire logic HSEL, // ahb slave select
  input wire logic [31:0] HADDR, // ahb address
  input wire logic [1:0] HTRANS, // ahb transfer type
  input wire logic HWRITE, // ahb write
  input wire logic [2:0] HSIZE, // ahb size, word only
  input wire logic [31:0] HWDATA, // ahb write data
  input wire logic HREADY, // ahb ready in
  output logic [31:0] HRDATA, // ahb read data
  output logic HREADYOUT, // ahb ready out
  output logic HRESP, // ahb response, always okay
  output bss_pkg::bss_setpoints_t SETPOINTS, // stored setpoint fields
  output logic [5:0] ACTIVE_CODE, // code in force
  output logic [15:0] TARGET_V // target, 100 uV units
);
  import bss_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bss_pwr_state_t prev_state_r, prev_state_nxt;
  bss_setpoints_t set_r, set_nxt;
  logic fuse_r, fuse_nxt;
  logic started_r, started_nxt;
  logic [CODE_W-1:0] code_r, code_nxt;
  logic [TGT_W-1:0] tgt_r, tgt_nxt;
  logic wr_ph_r, wr_ph_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic load_evt;
  logic wr_allow;
  logic addr_ph;

  // ---------------------------------------------------------------
  // start-up detect and setpoint fields
  // ---------------------------------------------------------------
  assign load_evt = (prev_state_r == BSS_OFF) && (PWR_STATE == BSS_RUN);
  // fuse is latched with the load so decode cannot flip mid-run
  assign wr_allow = !fuse_r && started_r && PROC_RESET_OUT_N;

  always_comb
  begin
    prev_state_nxt = PWR_STATE;
    set_nxt = set_r;
    fuse_nxt = fuse_r;
    started_nxt = started_r;
    // a power cycle closes the write window until the next load
    if (PWR_STATE == BSS_OFF)
    begin
      started_nxt = 1'b0;
    end
    if (load_evt)
    begin
      // load wins over a write landing in the same cycle
      set_nxt.run = FUSED_SETPOINT_CODE;
      set_nxt.stby = FUSED_SETPOINT_CODE;
      set_nxt.sleep = FUSED_SETPOINT_CODE;
      fuse_nxt = SCALING_SELECT_FUSE;
      started_nxt = 1'b1;
    end
    else if (wr_ph_r && wr_allow)
    begin
      unique case (addr_r)
        RUN_OFS: set_nxt.run = HWDATA[CODE_W-1:0];
        STBY_OFS: set_nxt.stby = HWDATA[CODE_W-1:0];
        SLEEP_OFS: set_nxt.sleep = HWDATA[CODE_W-1:0];
        default: set_nxt = set_r;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      prev_state_r <= BSS_OFF;
      set_r <= '{run: CODE_RST, stby: CODE_RST, sleep: CODE_RST};
      fuse_r <= 1'b0;
      started_r <= 1'b0;
    end
    else
    begin
      prev_state_r <= prev_state_nxt;
      set_r <= set_nxt;
      fuse_r <= fuse_nxt;
      started_r <= started_nxt;
    end
  end

  // ---------------------------------------------------------------
  // target select and decode
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (PWR_STATE)
      BSS_RUN: code_nxt = set_r.run;
      BSS_STBY: code_nxt = set_r.stby;
      BSS_SLEEP: code_nxt = set_r.sleep;
      // no rail in off; the run field keeps the decode defined
      BSS_OFF: code_nxt = set_r.run;
    endcase
    // worst scaled case is base plus 63 steps, well inside 16 bits
    if (!fuse_r)
    begin
      tgt_nxt = DVS_BASE + TGT_W'(code_nxt * DVS_STEP);
    end
    else if (code_nxt >= FIX_LAST)
    begin
      tgt_nxt = FIX_MAX;
    end
    else
    begin
      tgt_nxt = FIX_TABLE[code_nxt[2:0]];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      code_r <= CODE_RST;
      tgt_r <= DVS_BASE;
    end
    else
    begin
      code_r <= code_nxt;
      tgt_r <= tgt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  // no wait states: write data is taken one cycle after the address phase
  assign addr_ph = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);

  always_comb
  begin
    wr_ph_nxt = addr_ph && HWRITE;
    addr_nxt = addr_ph ? HADDR[7:0] : addr_r;
    rdata_nxt = rdata_r;
    if (addr_ph && !HWRITE)
    begin
      // read data is sampled here so it stands in the data phase
      rdata_nxt = '0;
      unique case (HADDR[7:0])
        RUN_OFS: rdata_nxt[CODE_W-1:0] = set_r.run;
        STBY_OFS: rdata_nxt[CODE_W-1:0] = set_r.stby;
        SLEEP_OFS: rdata_nxt[CODE_W-1:0] = set_r.sleep;
        STATUS_OFS:
        begin
          rdata_nxt[ST_STATE_LSB +: 2] = PWR_STATE;
          rdata_nxt[ST_FUSE_BIT] = fuse_r;
          rdata_nxt[ST_WREN_BIT] = wr_allow;
          rdata_nxt[ST_CODE_LSB +: CODE_W] = code_r;
          rdata_nxt[ST_TGT_LSB +: TGT_W] = tgt_r;
        end
        // unmapped reads give zero so software sees a clean miss
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wr_ph_r <= 1'b0;
      addr_r <= '0;
      rdata_r <= '0;
    end
    else
    begin
      wr_ph_r <= wr_ph_nxt;
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign HRDATA = rdata_r;
  // every access completes in one data phase and is always okay
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign SETPOINTS = set_r;
  assign ACTIVE_CODE = code_r;
  assign TARGET_V = tgt_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // one clock domain, so one default clocking serves every property
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  a_startup_load: assert property (
    load_evt |=> set_r.run == $past(FUSED_SETPOINT_CODE) && set_r.stby == set_r.run
      && set_r.sleep == set_r.run && started_r)
    else $error("start-up did not load fused code");

  a_state_select: assert property (
    (PWR_STATE == BSS_STBY) ##1 (PWR_STATE == BSS_SLEEP)
      |-> code_r == $past(set_r.stby) ##1 code_r == $past(set_r.sleep))
    else $error("active code does not follow state");

  a_write_accept: assert property (
    wr_ph_r && addr_r == STBY_OFS && !fuse_r && started_r && PROC_RESET_OUT_N && !load_evt
      |=> set_r.stby == $past(HWDATA[5:0]))
    else $error("permitted write not stored");

  a_fuse_readonly: assert property (
    fuse_r && !load_evt |=> $stable(set_r))
    else $error("field changed with scaling disabled");

  a_scaled_map: assert property (
    !$past(fuse_r) |-> tgt_r == DVS_BASE + TGT_W'(code_r * DVS_STEP))
    else $error("scaled target wrong");

  a_fixed_top: assert property (
    $past(fuse_r) && code_r >= FIX_LAST |-> tgt_r == FIX_MAX)
    else $error("fixed target above code 6 not 3.30 V");

  a_early_ignore: assert property (
    wr_ph_r && !PROC_RESET_OUT_N && !load_evt |=> $stable(set_r))
    else $error("write taken before reset released");

  c_startup: cover property (load_evt ##1 PWR_STATE == BSS_STBY);
  c_host_write: cover property (wr_ph_r && wr_allow && addr_r == RUN_OFS);
  c_fixed_read: cover property (fuse_r && addr_ph && !HWRITE);
  c_sleep_select: cover property (PWR_STATE == BSS_SLEEP ##1 code_r == set_r.sleep);
  c_early_write: cover property (wr_ph_r && !PROC_RESET_OUT_N);

  // ---------------------------------------------------------------
  // field selection and read-back
  // ---------------------------------------------------------------
  a_run_select: assert property (
    PWR_STATE == BSS_RUN |=> code_r == $past(set_r.run))
    else $error("active code does not follow run field");

  // read data is registered, so it shows the field as it stood in the address phase
  a_read_back: assert property (
    addr_ph && !HWRITE && HADDR[7:0] == STBY_OFS
      |=> HRDATA[CODE_W-1:0] == $past(set_r.stby))
    else $error("read data does not show standby field");

  // ---------------------------------------------------------------
  // write window and field holding
  // ---------------------------------------------------------------
  a_run_write: assert property (
    wr_ph_r && addr_r == RUN_OFS && wr_allow && !load_evt
      |=> set_r.run == $past(HWDATA[CODE_W-1:0]))
    else $error("permitted run write not stored");

  // a stale window after power off would let old host writes land
  a_off_clears: assert property (
    PWR_STATE == BSS_OFF |=> !started_r && !wr_allow)
    else $error("writes still allowed after power off");

  // with the fuse set, status must show the fields as locked
  a_status_locked: assert property (
    addr_ph && !HWRITE && HADDR[7:0] == STATUS_OFS && fuse_r
      |=> HRDATA[ST_FUSE_BIT] && !HRDATA[ST_WREN_BIT])
    else $error("status does not show fields locked");

  // fields move only on a load or on a permitted write
  a_loaded_hold: assert property (
    !load_evt && !(wr_ph_r && wr_allow) |=> $stable(set_r))
    else $error("setpoint field moved without load or write");

  // ---------------------------------------------------------------
  // fuse latch and low end of both voltage tables
  // ---------------------------------------------------------------
  // the load must latch the fuse so the decode cannot flip mid-run
  a_fuse_latch: assert property (
    load_evt |=> fuse_r == $past(SCALING_SELECT_FUSE))
    else $error("fuse not latched at start-up");

  a_scaled_floor: assert property (
    !$past(fuse_r) && code_r == CODE_RST |-> tgt_r == DVS_BASE)
    else $error("scaled code zero not at base voltage");

  a_scaled_step: assert property (
    !$past(fuse_r) && code_r == 6'h01 |-> tgt_r == DVS_BASE + DVS_STEP)
    else $error("scaled code one not one step above base");

  a_fixed_floor: assert property (
    $past(fuse_r) && code_r == CODE_RST |-> tgt_r == FIX_TABLE[0])
    else $error("fixed code zero not at lowest table entry");

endmodule

/* File: tb.sv */
// self-checking bench for the buck setpoint select block
`timescale 1ns/1ps
module tb;
  import bss_pkg::*;
  logic clk = 0, rstn = 0, fuse = 0, hsel = 0, hwrite = 0;
  logic [5:0] fc = 6'h00;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  bss_pwr_state_t req = BSS_OFF, st;
  logic prn, hready, hresp;
  logic [31:0] hrdata;
  bss_setpoints_t sp;
  logic [5:0] act;
  logic [15:0] tv;
  int n_mismatch = 0, tests_run = 0, seed = 37;
  logic [5:0] c [3];
  bss_pwr_state_t sts [3] = '{BSS_RUN, BSS_STBY, BSS_SLEEP};
  logic [7:0] ofs [3] = '{RUN_OFS, STBY_OFS, SLEEP_OFS};
  initial forever #5 clk = ~clk;
  bss_seq_model #(.RELEASE_DLY(12)) i_seq (.clk(clk), .rst_n(rstn), .req(req), .state(st),
    .proc_rst_out_n(prn));
  bss_top i_dut (.CORE_CLK(clk), .RESETN(rstn), .PWR_STATE(st), .PROC_RESET_OUT_N(prn),
    .FUSED_SETPOINT_CODE(fc), .SCALING_SELECT_FUSE(fuse), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SETPOINTS(sp), .ACTIVE_CODE(act),
    .TARGET_V(tv));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] tgt(input logic f, input logic [5:0] k);
    logic [15:0] fix [8] = '{16'h2af8, 16'h2ee0, 16'h34bc, 16'h3a98,
      16'h4650, 16'h61a8, 16'h7530, 16'h80e8};
    if (f)
      return fix[(k > 6'h07) ? 3'h7 : k[2:0]];
    return 16'h1770 + 16'h007d * {10'h0, k};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic power_up(input logic [5:0] k);
    req <= BSS_OFF;
    repeat (3) @(posedge clk);
    fc <= k;
    req <= BSS_RUN;
    repeat (4) @(posedge clk);
    chk({14'h0, sp}, {14'h0, k, k, k});
    chk({16'h0, tv}, {16'h0, tgt(fuse, k)});
    if (!fuse)
      bus(1'b1, RUN_OFS, {26'h0, ~k});
    repeat (2) @(posedge clk);
    chk({14'h0, sp}, {14'h0, k, k, k});
    repeat (16) @(posedge clk);
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    power_up(6'($random(seed)));
    for (int i = 0; i < 8; i++)
    begin
      // corner codes first, then random ones
      for (int j = 0; j < 3; j++)
        c[j] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : (i == 2) ? 6'h01 : 6'($random(seed));
      for (int j = 0; j < 3; j++)
        bus(1'b1, ofs[j], {26'h0, c[j]});
      for (int j = 0; j < 3; j++)
      begin
        bus(1'b0, ofs[j], 32'h0);
        chk(q, {26'h0, c[j]});
        req <= sts[j];
        repeat (4) @(posedge clk);
        chk({26'h0, act}, {26'h0, c[j]});
        chk({16'h0, tv}, {16'h0, tgt(1'b0, c[j])});
      end
    end
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(q, {tgt(1'b0, c[2]), 2'b00, c[2], 4'h0, 2'b10, 2'b11});
    fuse <= 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      power_up((k < 8) ? 6'(k) : 6'h3f);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk(q, {tgt(1'b1, fc), 2'b00, fc, 4'h0, 2'b01, 2'b01});
      repeat (2) @(posedge clk);
      chk({26'h0, sp.stby}, {26'h0, fc});
    end
    close_out();
  end
endmodule
